// *** hdl/fsrc_pkg.sv ***
package fsrc_pkg;
   // opcodes
   localparam logic [7:0] OP_IDLE = 8'h00;
   localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
   localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_READ_STATUS = 8'h05;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_SMALL_WIPE = 8'h20;
   localparam logic [7:0] OP_QUAD_PAGE_WRITE = 8'h38;
   localparam logic [7:0] OP_HALF_WIPE = 8'h52;
   localparam logic [7:0] OP_CHIP_WIPE = 8'h60;
   localparam logic [7:0] OP_CHIP_WIPE_ALT = 8'hC7;
   localparam logic [7:0] OP_LARGE_WIPE = 8'hD8;
   localparam logic [7:0] OP_READ_IDS = 8'h90;
   localparam logic [7:0] OP_RESET_ARM = 8'h66;
   localparam logic [7:0] OP_RESET_MEMORY = 8'h99;
   localparam logic [7:0] OP_LOCK_QUERY = 8'hE4;
   localparam logic [7:0] OP_LOCK_BIT_HI = 8'hE2;
   localparam logic [7:0] OP_LOCK_BIT_LO = 8'hE0;
   localparam logic [7:0] OP_PASS_FIRST = 8'h27;
   localparam logic [7:0] OP_PASS_LAST = 8'h29;
   // status field positions and reset value
   localparam int BIT_BUSY = 0;
   localparam int BIT_WEL = 1;
   localparam int BIT_PROT_LO = 2;
   localparam int BIT_PROT_HI = 5;
   localparam int BIT_QE = 6;
   localparam int BIT_SWD = 7;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   // frame layout in bytes, opcode is byte 0
   localparam logic [2:0] ADDR_BYTES_3 = 3'h3;
   localparam logic [2:0] ADDR_BYTES_4 = 3'h4;
   localparam logic [2:0] IDS_SEL_BYTE = 3'h3;
   localparam logic [2:0] IDS_DATA_BYTE = 3'h4;
   localparam logic [7:0] IDS_SEL_MFR = 8'h00;
   localparam logic [7:0] IDS_SEL_DEV = 8'h01;
   // identity bytes, values arbitrary
   localparam logic [7:0] ID_MAKER = 8'h5A;
   localparam logic [7:0] ID_PART = 8'h3C;
   // operation times
   localparam int CLK_PERIOD_NS = 100;
   localparam int T_PAGE_WRITE_NS = 20000;
   localparam int T_WIPE_NS = 300000;
   localparam int T_CHIP_WIPE_NS = 400000;
   localparam int T_STATUS_WRITE_NS = 40000;
   localparam logic [11:0] CYC_PAGE_WRITE =
      12'((T_PAGE_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] CYC_WIPE =
      12'((T_WIPE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] CYC_CHIP_WIPE =
      12'((T_CHIP_WIPE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] CYC_STATUS_WRITE =
      12'((T_STATUS_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   typedef enum logic {ST_IDLE, ST_BUSY} fsrc_state_t;
endpackage : fsrc_pkg

// *** hdl/fsrc_core.sv ***
// Summary of operation
// - ID select 00H maker first, 01H part
// - 66h then 99h resets; else ignored
// - field lengths in bytes; four-byte adds
// - lock commands framed, payload ignored here
// - bit 0 busy during write cycles
// - write-enable command sets latch
// - program/erase dropped without latch
// - latch clears when operation finishes
// - protected target: no op, latch cleared
// - bits 5..2 protect level, status write only
// - chip wipe only at level zero
// - quad off: quad ignored, pins wp/reset
// - quad on: 38h taken on si, lanes 2/3 unused, no perf/reset pin
// - swd and wp low block status write, quad off only
// - swd and quad enable reset zero
module fsrc_core
   import fsrc_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic cs_b,
   input wire logic si,
   output logic so_out,
   output logic so_oe,
   input wire logic io2_in,
   output logic io2_out,
   output logic io2_oe,
   input wire logic io3_in,
   output logic io3_out,
   output logic io3_oe,
   input wire logic four_byte_addr,
   output logic [7:0] flash_status,
   output logic write_in_progress,
   output logic write_enable_latch,
   output logic quad_io_enable,
   output logic high_perf_allow,
   output logic soft_reset_pulse
);
   // ---------------- link domain (sclk) ----------------
   logic [2:0] bit_cnt_reg, bit_cnt_next;
   logic [6:0] rx_shift_reg, rx_shift_next;
   logic [2:0] lk_idx_reg, lk_idx_next;
   logic [7:0] lk_cmd_reg, lk_cmd_next;
   logic lk_sel_reg, lk_sel_next;
   logic id_phase_reg, id_phase_next;
   logic [7:0] rx_byte_reg, rx_byte_next;
   logic rx_tog_reg, rx_tog_next;
   logic st_s1_reg, st_s2_reg, st_seen_reg, st_seen_next;
   logic [7:0] st_copy_reg, st_copy_next;
   logic [7:0] tx_shift_reg, tx_shift_next;
   logic so_reg, so_next, resp_reg, resp_next;
   logic [7:0] rx_full, resp_byte;
   logic resp_valid;
   // core-side status hand-over
   logic [7:0] hold_reg, hold_next;
   logic hold_tog_reg, hold_tog_next;

   always_comb begin
      rx_full = {rx_shift_reg, si};
      bit_cnt_next = bit_cnt_reg + 3'h1;
      rx_shift_next = rx_full[6:0];
      lk_idx_next = lk_idx_reg;
      lk_cmd_next = lk_cmd_reg;
      lk_sel_next = lk_sel_reg;
      id_phase_next = id_phase_reg;
      rx_byte_next = rx_byte_reg;
      rx_tog_next = rx_tog_reg;
      if (bit_cnt_reg == 3'h7) begin
         rx_byte_next = rx_full;
         rx_tog_next = ~rx_tog_reg;
         if (lk_idx_reg == 3'h0) lk_cmd_next = rx_full;
         if (lk_cmd_reg == OP_READ_IDS && lk_idx_reg == IDS_SEL_BYTE)
            lk_sel_next = (rx_full == IDS_SEL_DEV);
         if (lk_idx_reg >= IDS_DATA_BYTE) id_phase_next = ~id_phase_reg;
         if (lk_idx_reg != 3'h7) lk_idx_next = lk_idx_reg + 3'h1;
      end
   end

   // frame-scoped link state: cleared whenever chip select is high
   always_ff @(posedge sclk or posedge cs_b or negedge rst_b) begin
      if (!rst_b || cs_b) begin
         bit_cnt_reg <= 3'h0;
         rx_shift_reg <= 7'h00;
         lk_idx_reg <= 3'h0;
         lk_cmd_reg <= OP_IDLE;
         lk_sel_reg <= 1'b0;
         id_phase_reg <= 1'b0;
      end else begin
         bit_cnt_reg <= bit_cnt_next;
         rx_shift_reg <= rx_shift_next;
         lk_idx_reg <= lk_idx_next;
         lk_cmd_reg <= lk_cmd_next;
         lk_sel_reg <= lk_sel_next;
         id_phase_reg <= id_phase_next;
      end
   end

   // status copy taken once the hold toggle has crossed
   always_comb begin
      st_seen_next = st_s2_reg;
      st_copy_next = (st_s2_reg != st_seen_reg) ? hold_reg : st_copy_reg;
   end

   always_ff @(posedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         rx_byte_reg <= 8'h00;
         rx_tog_reg <= 1'b0;
         st_s1_reg <= 1'b0;
         st_s2_reg <= 1'b0;
         st_seen_reg <= 1'b0;
         st_copy_reg <= STATUS_RESET;
      end else begin
         rx_byte_reg <= rx_byte_next;
         rx_tog_reg <= rx_tog_next;
         st_s1_reg <= hold_tog_reg;
         st_s2_reg <= st_s1_reg;
         st_seen_reg <= st_seen_next;
         st_copy_reg <= st_copy_next;
      end
   end

   // reply byte chosen at each byte boundary
   always_comb begin
      resp_valid = 1'b0;
      resp_byte = 8'h00;
      if (lk_cmd_reg == OP_READ_STATUS && lk_idx_reg != 3'h0) begin
         resp_valid = 1'b1;
         resp_byte = st_copy_reg;
      end else if (lk_cmd_reg == OP_READ_IDS &&
                   lk_idx_reg >= IDS_DATA_BYTE) begin
         resp_valid = 1'b1;
         resp_byte = (id_phase_reg ^ lk_sel_reg) ? ID_PART : ID_MAKER;
      end
      if (bit_cnt_reg == 3'h0) begin
         tx_shift_next = resp_byte;
         so_next = resp_byte[7];
         resp_next = resp_valid;
      end else begin
         tx_shift_next = {tx_shift_reg[6:0], 1'b0};
         so_next = tx_shift_reg[6];
         resp_next = resp_reg;
      end
   end

   always_ff @(negedge sclk or posedge cs_b or negedge rst_b) begin
      if (!rst_b || cs_b) begin
         tx_shift_reg <= 8'h00;
         so_reg <= 1'b0;
         resp_reg <= 1'b0;
      end else begin
         tx_shift_reg <= tx_shift_next;
         so_reg <= so_next;
         resp_reg <= resp_next;
      end
   end

   assign so_out = so_reg;
   assign so_oe = resp_reg & ~cs_b;

   // ---------------- core domain (clock) ----------------
   logic rx_s1_reg, rx_s2_reg, rx_seen_reg;
   logic cs_s1_reg, cs_s2_reg, cs_s3_reg, cs_prev_reg;
   logic wp_s1_reg, wp_s2_reg, rp_s1_reg, rp_s2_reg;
   logic ack_s1_reg, ack_s2_reg;
   fsrc_state_t state_reg, state_next;
   logic [11:0] busy_cnt_reg, busy_cnt_next;
   logic wel_reg, wel_next, qe_reg, qe_next, swd_reg, swd_next;
   logic [3:0] prot_reg, prot_next;
   logic [2:0] idx_reg, idx_next;
   logic [7:0] cmd_reg, cmd_next, data_reg, data_next;
   logic [31:0] addr_reg, addr_next;
   logic arm_reg, arm_next, srst_reg, srst_next;
   logic byte_evt, frame_end, hw_prot, pin_reset, is_pe, chip, prot_hit;
   logic [2:0] abytes;
   logic [3:0] addr_top;
   logic [11:0] op_cycles;
   logic [7:0] status_now;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rx_s1_reg <= 1'b0;
         rx_s2_reg <= 1'b0;
         rx_seen_reg <= 1'b0;
         cs_s1_reg <= 1'b1;
         cs_s2_reg <= 1'b1;
         cs_s3_reg <= 1'b1;
         cs_prev_reg <= 1'b1;
         wp_s1_reg <= 1'b1;
         wp_s2_reg <= 1'b1;
         rp_s1_reg <= 1'b1;
         rp_s2_reg <= 1'b1;
         ack_s1_reg <= 1'b0;
         ack_s2_reg <= 1'b0;
      end else begin
         rx_s1_reg <= rx_tog_reg;
         rx_s2_reg <= rx_s1_reg;
         rx_seen_reg <= rx_s2_reg;
         cs_s1_reg <= cs_b;
         cs_s2_reg <= cs_s1_reg;
         cs_s3_reg <= cs_s2_reg;
         cs_prev_reg <= cs_s3_reg;
         wp_s1_reg <= io2_in;
         wp_s2_reg <= wp_s1_reg;
         rp_s1_reg <= io3_in;
         rp_s2_reg <= rp_s1_reg;
         ack_s1_reg <= st_seen_reg;
         ack_s2_reg <= ack_s1_reg;
      end
   end

   always_comb begin
      byte_evt = rx_s2_reg ^ rx_seen_reg;
      // extra stage: last byte always lands before the frame end
      frame_end = cs_s3_reg & ~cs_prev_reg;
      hw_prot = swd_reg & ~wp_s2_reg & ~qe_reg;
      pin_reset = ~qe_reg & ~rp_s2_reg;
      abytes = four_byte_addr ? ADDR_BYTES_4 : ADDR_BYTES_3;
      addr_top = four_byte_addr ? addr_reg[31:28] : addr_reg[23:20];
      prot_hit = (prot_reg != 4'h0) &&
                 ({1'b0, addr_top} >= 5'h10 - {1'b0, prot_reg});
      status_now = {swd_reg, qe_reg, prot_reg, wel_reg,
                    state_reg == ST_BUSY};
      chip = (cmd_reg == OP_CHIP_WIPE) || (cmd_reg == OP_CHIP_WIPE_ALT);
      is_pe = 1'b1;
      op_cycles = CYC_WIPE;
      if (chip) begin
         is_pe = (idx_reg == 3'h1);
         op_cycles = CYC_CHIP_WIPE;
      end else if (cmd_reg == OP_PAGE_WRITE ||
                   (cmd_reg == OP_QUAD_PAGE_WRITE && qe_reg)) begin
         is_pe = (idx_reg >= abytes + 3'h2);
         op_cycles = CYC_PAGE_WRITE;
      end else if (cmd_reg == OP_SMALL_WIPE || cmd_reg == OP_HALF_WIPE ||
                   cmd_reg == OP_LARGE_WIPE) begin
         is_pe = (idx_reg == abytes + 3'h1);
      end else begin
         is_pe = 1'b0;
      end
   end

   always_comb begin
      state_next = state_reg;
      busy_cnt_next = busy_cnt_reg;
      wel_next = wel_reg;
      qe_next = qe_reg;
      swd_next = swd_reg;
      prot_next = prot_reg;
      idx_next = idx_reg;
      cmd_next = cmd_reg;
      data_next = data_reg;
      addr_next = addr_reg;
      arm_next = arm_reg;
      srst_next = 1'b0;
      if (byte_evt) begin
         if (idx_reg == 3'h0) cmd_next = rx_byte_reg;
         else if (idx_reg <= abytes)
            addr_next = {addr_reg[23:0], rx_byte_reg};
         if (idx_reg == 3'h1) data_next = rx_byte_reg;
         if (idx_reg != 3'h7) idx_next = idx_reg + 3'h1;
      end
      if (state_reg == ST_BUSY) begin
         if (busy_cnt_reg == 12'h001) begin
            state_next = ST_IDLE;
            wel_next = 1'b0;
         end
         busy_cnt_next = busy_cnt_reg - 12'h001;
      end
      if (frame_end) begin
         idx_next = 3'h0;
         cmd_next = OP_IDLE;
         if (idx_reg != 3'h0) begin
            // any other command, idle included, disarms reset
            arm_next = (cmd_reg == OP_RESET_ARM) && (idx_reg == 3'h1);
            if (cmd_reg == OP_RESET_MEMORY && arm_reg &&
                idx_reg == 3'h1) begin
               srst_next = 1'b1;
            end else if (state_reg == ST_IDLE) begin
               if (cmd_reg == OP_WRITE_ENABLE && idx_reg == 3'h1) begin
                  wel_next = 1'b1;
               end else if (cmd_reg == OP_WRITE_DISABLE) begin
                  wel_next = 1'b0;
               end else if (cmd_reg == OP_WRITE_STATUS &&
                            idx_reg >= 3'h2 && wel_reg && !hw_prot) begin
                  swd_next = data_reg[BIT_SWD];
                  qe_next = data_reg[BIT_QE];
                  prot_next = data_reg[BIT_PROT_HI:BIT_PROT_LO];
                  state_next = ST_BUSY;
                  busy_cnt_next = CYC_STATUS_WRITE;
               end else if (is_pe && !wel_reg) begin
                  wel_next = 1'b0;
               end else if (is_pe && (chip ? prot_reg != 4'h0
                                           : prot_hit)) begin
                  wel_next = 1'b0;
               end else if (is_pe) begin
                  state_next = ST_BUSY;
                  busy_cnt_next = op_cycles;
               end
               // lock and password frames carry no status effect
            end
         end
      end
      if (srst_reg || pin_reset) begin
         state_next = ST_IDLE;
         busy_cnt_next = 12'h000;
         wel_next = 1'b0;
         arm_next = 1'b0;
      end
      // new status snapshot only once the last one was acknowledged
      hold_next = hold_reg;
      hold_tog_next = hold_tog_reg;
      if (ack_s2_reg == hold_tog_reg && status_now != hold_reg) begin
         hold_next = status_now;
         hold_tog_next = ~hold_tog_reg;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= ST_IDLE;
         busy_cnt_reg <= 12'h000;
         wel_reg <= STATUS_RESET[BIT_WEL];
         qe_reg <= STATUS_RESET[BIT_QE];
         swd_reg <= STATUS_RESET[BIT_SWD];
         prot_reg <= STATUS_RESET[BIT_PROT_HI:BIT_PROT_LO];
         idx_reg <= 3'h0;
         cmd_reg <= OP_IDLE;
         data_reg <= 8'h00;
         addr_reg <= 32'h0000_0000;
         arm_reg <= 1'b0;
         srst_reg <= 1'b0;
         hold_reg <= STATUS_RESET;
         hold_tog_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         busy_cnt_reg <= busy_cnt_next;
         wel_reg <= wel_next;
         qe_reg <= qe_next;
         swd_reg <= swd_next;
         prot_reg <= prot_next;
         idx_reg <= idx_next;
         cmd_reg <= cmd_next;
         data_reg <= data_next;
         addr_reg <= addr_next;
         arm_reg <= arm_next;
         srst_reg <= srst_next;
         hold_reg <= hold_next;
         hold_tog_reg <= hold_tog_next;
      end
   end

   assign flash_status = status_now;
   assign write_in_progress = (state_reg == ST_BUSY);
   assign write_enable_latch = wel_reg;
   assign quad_io_enable = qe_reg;
   assign high_perf_allow = ~qe_reg;
   assign soft_reset_pulse = srst_reg;
   // lanes 2/3 are inputs only in this block
   assign io2_out = 1'b0;
   assign io2_oe = 1'b0;
   assign io3_out = 1'b0;
   assign io3_oe = 1'b0;

   // ---------------- checks ----------------
   property p_write_enable_cmd_sets;
      @(posedge clock) disable iff (!rst_b)
      frame_end && !srst_reg && !pin_reset && state_reg == ST_IDLE &&
      cmd_reg == OP_WRITE_ENABLE && idx_reg == 3'h1
      |=> write_enable_latch;
   endproperty
   a_write_enable_cmd_sets: assert property (p_write_enable_cmd_sets)
      else $error("write enable did not set latch");

   property p_no_wel_drop;
      @(posedge clock) disable iff (!rst_b)
      frame_end && is_pe && !wel_reg && state_reg == ST_IDLE
      |=> !write_in_progress;
   endproperty
   a_no_wel_drop: assert property (p_no_wel_drop)
      else $error("program or erase ran without latch");

   property p_done_clears;
      @(posedge clock) disable iff (!rst_b)
      $fell(write_in_progress) |-> !write_enable_latch;
   endproperty
   a_done_clears: assert property (p_done_clears)
      else $error("latch still set after operation end");

   property p_prot_reject;
      @(posedge clock) disable iff (!rst_b)
      frame_end && is_pe && wel_reg && state_reg == ST_IDLE && !chip &&
      prot_hit && !pin_reset
      |=> !write_in_progress && !write_enable_latch;
   endproperty
   a_prot_reject: assert property (p_prot_reject)
      else $error("protected target was not rejected");

   property p_chip_level;
      @(posedge clock) disable iff (!rst_b)
      frame_end && is_pe && chip && prot_reg != 4'h0 && idx_reg != 3'h0 &&
      state_reg == ST_IDLE
      |=> !write_in_progress;
   endproperty
   a_chip_level: assert property (p_chip_level)
      else $error("chip wipe ran with protection set");

   property p_busy_len;
      @(posedge clock) disable iff (!rst_b)
      $rose(write_in_progress) && !srst_reg
      |-> write_in_progress[*8];
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("busy flag dropped too early");

   property p_hw_prot;
      @(posedge clock) disable iff (!rst_b)
      hw_prot && frame_end && cmd_reg == OP_WRITE_STATUS &&
      state_reg == ST_IDLE
      |=> $stable(flash_status[7:2]) && !write_in_progress;
   endproperty
   a_hw_prot: assert property (p_hw_prot)
      else $error("status write accepted under protection");

   property p_reset_pair;
      @(posedge clock) disable iff (!rst_b)
      frame_end && cmd_reg == OP_RESET_MEMORY && !arm_reg
      |=> !soft_reset_pulse;
   endproperty
   a_reset_pair: assert property (p_reset_pair)
      else $error("reset taken without arming");

   property p_reset_done;
      @(posedge clock) disable iff (!rst_b)
      soft_reset_pulse |=> !write_enable_latch && !write_in_progress;
   endproperty
   a_reset_done: assert property (p_reset_done)
      else $error("soft reset left latch or busy set");

   property p_quad_pins;
      @(posedge clock) disable iff (!rst_b)
      high_perf_allow == !quad_io_enable && !io2_oe && !io3_oe;
   endproperty
   a_quad_pins: assert property (p_quad_pins)
      else $error("quad pin function wrong");

   c_op_done: cover property (@(posedge clock) disable iff (!rst_b)
      $fell(write_in_progress));
   c_soft_reset: cover property (@(posedge clock) disable iff (!rst_b)
      soft_reset_pulse);
   c_prot_hit: cover property (@(posedge clock) disable iff (!rst_b)
      frame_end && is_pe && wel_reg && prot_hit);
endmodule : fsrc_core

// *** verif/fsrc_host.sv ***
module fsrc_host (
   output logic sclk,
   output logic cs_b,
   output logic si,
   input wire logic so_out
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      sclk = 1'b0;
      cs_b = 1'b1;
      si = 1'b0;
   end

   // n bytes, first byte at the top of the n-byte field, msb first
   task automatic frame(input int n, input logic [47:0] tx,
                        output logic [47:0] rx);
      int i;
      int k;
      rx = '0;
      cs_b = 1'b0;
      for (i = n - 1; i >= 0; i--) begin
         for (k = 7; k >= 0; k--) begin
            si = tx[8 * i + k];
            #24 sclk = 1'b1;
            rx[8 * i + k] = so_out;
            #24 sclk = 1'b0;
         end
      end
      #24 cs_b = 1'b1;
      // released line must not keep its last level
      si = ~si;
      // gap lets the core act on the frame
      #600;
   endtask : frame
endmodule : fsrc_host

// *** verif/testbench.sv ***
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import fsrc_pkg::*;
   logic clock, rst_b, sclk, cs_b, si, so_out, so_oe;
   logic io2_in, io2_out, io2_oe, io3_in, io3_out, io3_oe;
   logic wp_level, rst_pin, four_byte_addr;
   logic [7:0] flash_status;
   logic write_in_progress, write_enable_latch, quad_io_enable;
   logic high_perf_allow, soft_reset_pulse;
   int miscompares = 0;
   int n_compared = 0;
   int pulses = 0;
   int oe_bits = 0;

   assign io2_in = io2_oe ? io2_out : wp_level;
   assign io3_in = io3_oe ? io3_out : rst_pin;

   fsrc_core fsrc_core_inst (.clock(clock), .rst_b(rst_b), .sclk(sclk),
      .cs_b(cs_b), .si(si), .so_out(so_out), .so_oe(so_oe),
      .io2_in(io2_in), .io2_out(io2_out), .io2_oe(io2_oe),
      .io3_in(io3_in), .io3_out(io3_out), .io3_oe(io3_oe),
      .four_byte_addr(four_byte_addr), .flash_status(flash_status),
      .write_in_progress(write_in_progress),
      .write_enable_latch(write_enable_latch),
      .quad_io_enable(quad_io_enable), .high_perf_allow(high_perf_allow),
      .soft_reset_pulse(soft_reset_pulse));

   fsrc_host fsrc_host_inst (.sclk(sclk), .cs_b(cs_b), .si(si),
      .so_out(so_out));

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   always @(posedge clock) begin
      if (soft_reset_pulse === 1'b1) begin
         pulses++;
      end
   end

   always @(posedge sclk) begin
      if (so_oe === 1'b1) begin
         oe_bits++;
      end
   end

   task automatic stop_test();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic cmd(input int n, input logic [47:0] tx);
      logic [47:0] rx;
      fsrc_host_inst.frame(n, tx, rx);
      // look at outputs away from the clock edge
      @(negedge clock);
   endtask : cmd

   task automatic pin_pulse();
      @(posedge clock);
      rst_pin <= 1'b0;
      repeat (4) @(negedge clock);
      @(posedge clock);
      rst_pin <= 1'b1;
      repeat (3) @(negedge clock);
   endtask : pin_pulse

   task automatic rd_status(output logic [7:0] s);
      logic [47:0] rx;
      // several reply bytes; the first may lag one update
      fsrc_host_inst.frame(4, 48'h05_00_00_00, rx);
      s = rx[7:0];
   endtask : rd_status

   task automatic wait_idle();
      logic [7:0] s;
      int i;
      s = 8'h01;
      for (i = 0; i < 400 && s[0] !== 1'b0; i++) begin
         rd_status(s);
      end
      chk(s & 8'h01, 8'h00);
      @(negedge clock);
   endtask : wait_idle

   task automatic t_reset_values();
      chk(flash_status, STATUS_RESET);
      chk({7'h00, high_perf_allow}, 8'h01);
   endtask : t_reset_values

   task automatic t_latch();
      logic [7:0] s;
      cmd(1, 48'h06);
      rd_status(s);
      chk(s, 8'h02);
      pin_pulse();
      chk(flash_status, 8'h00);
      cmd(1, 48'h06);
      cmd(1, 48'h04);
      cmd(5, 48'h02_00_00_10_AA);
      chk(flash_status, 8'h00);
   endtask : t_latch

   task automatic t_program();
      logic [7:0] s;
      @(posedge clock);
      four_byte_addr <= 1'b1;
      cmd(1, 48'h06);
      cmd(5, 48'h02_00_00_00_10);
      chk(flash_status, 8'h02);
      cmd(6, 48'h02_00_00_00_10_AA);
      chk(flash_status, 8'h03);
      chk({write_in_progress, write_enable_latch, io2_oe, io3_oe}, 8'h0C);
      chk({io2_out, io3_out}, 8'h00);
      rd_status(s);
      chk(s & 8'h01, 8'h01);
      wait_idle();
      chk(flash_status, 8'h00);
      @(posedge clock);
      four_byte_addr <= 1'b0;
   endtask : t_program

   task automatic t_protect();
      cmd(1, 48'h06);
      cmd(2, 48'h01_84);
      chk(flash_status, 8'h87);
      wait_idle();
      chk(flash_status, 8'h84);
      cmd(1, 48'h06);
      cmd(5, 48'h02_F0_00_00_55);
      chk(flash_status, 8'h84);
      cmd(1, 48'h06);
      cmd(1, 48'h60);
      chk(flash_status, 8'h84);
      cmd(1, 48'h06);
      cmd(1, 48'hC7);
      chk(flash_status, 8'h84);
   endtask : t_protect

   task automatic t_hw_quad();
      @(posedge clock);
      wp_level <= 1'b0;
      cmd(1, 48'h06);
      cmd(2, 48'h01_00);
      chk(flash_status & 8'hFD, 8'h84);
      @(posedge clock);
      wp_level <= 1'b1;
      cmd(1, 48'h06);
      cmd(5, 48'h38_00_00_10_AA);
      chk(flash_status, 8'h86);
      cmd(1, 48'h06);
      cmd(2, 48'h01_40);
      wait_idle();
      chk(flash_status, 8'h40);
      chk({quad_io_enable, high_perf_allow}, 8'h02);
      cmd(1, 48'h06);
      cmd(5, 48'h38_00_00_10_AA);
      chk(flash_status, 8'h43);
      wait_idle();
      chk(flash_status, 8'h40);
      cmd(1, 48'h06);
      pin_pulse();
      chk(flash_status, 8'h42);
   endtask : t_hw_quad

   task automatic t_soft_reset();
      logic [7:0] mid [2];
      int n;
      int i;
      mid = '{8'h00, 8'hE4};
      for (i = 0; i < 2; i++) begin
         n = pulses;
         cmd(1, 48'h06);
         cmd(1, 48'h66);
         cmd(1, {40'h0, mid[i]});
         cmd(1, 48'h99);
         chk(flash_status, 8'h42);
         chk(8'(pulses - n), 8'h00);
      end
      n = pulses;
      cmd(1, 48'h66);
      cmd(1, 48'h99);
      chk(8'(pulses - n), 8'h01);
      chk(flash_status, 8'h40);
   endtask : t_soft_reset

   task automatic t_ids();
      logic [47:0] rx;
      int n;
      n = oe_bits;
      fsrc_host_inst.frame(6, 48'h90_00_00_00_00_00, rx);
      chk(rx[15:8], ID_MAKER);
      chk(rx[7:0], ID_PART);
      chk(8'(oe_bits - n), 8'h10);
      fsrc_host_inst.frame(6, 48'h90_00_00_01_00_00, rx);
      chk(rx[15:8], ID_PART);
      chk(rx[7:0], ID_MAKER);
   endtask : t_ids

   initial begin
      #5000000;
      miscompares++;
      stop_test();
   end

   initial begin
      rst_b = 1'b0;
      wp_level = 1'b1;
      rst_pin = 1'b1;
      four_byte_addr = 1'b0;
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      repeat (2) @(posedge clock);
      t_reset_values();
      t_latch();
      t_program();
      t_protect();
      t_hw_quad();
      t_soft_reset();
      t_ids();
      stop_test();
   end
endmodule : testbench
